//--- core_model.sv
// Purpose: Behavioural processor core that takes interrupt requests
// Assumes: Requests are levels on irq_high and irq_low, one clock
// Notes: One entry per arming of take_en, after ack_delay cycles
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic ref_clk,
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic take_en,
  input wire logic [3:0] ack_delay,
  output logic entry_ack,
  output logic [7:0] core_working,
  output logic [7:0] core_status,
  output logic [7:0] core_bank
);
  logic [3:0] wait_reg; // Cycles left before entry
  logic done_reg; // Blocks a second entry while armed
  // Distinct context values so a swapped save shows up
  assign core_working = 8'h5A; // Offered for the shadow copy
  assign core_status = 8'hC3;
  assign core_bank = 8'h0E;
  // Entry sequencer; a large ack_delay makes a slow core
  always_ff @(posedge ref_clk) begin
    entry_ack <= 1'b0;
    if (!take_en) begin
      // Disarmed: reload the delay
      done_reg <= 1'b0;
      wait_reg <= ack_delay;
    end else if (!done_reg && (irq_high || irq_low)) begin
      if (wait_reg == 4'h0) begin
        // Entry pulse; the service code then relies on the shadow copy
        entry_ack <= 1'b1;
        done_reg <= 1'b1;
      end else begin
        wait_reg <= wait_reg - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- irq_prio_pkg.sv
// Purpose: Constants for the interrupt priority and source block
// Assumes: 8-bit register port, synchronous active-high reset
// Notes: Offsets are register indices on the plain register port
package irq_prio_pkg;
  // Register map
  localparam logic [3:0] ADDR_PRIO_TWO = 4'h0;
  localparam logic [3:0] ADDR_PRIO_THREE = 4'h1;
  localparam logic [3:0] ADDR_RESET_CAUSE = 4'h2;
  localparam logic [3:0] ADDR_IRQ_CTRL = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CTRL_B = 4'h4;
  localparam logic [3:0] ADDR_IRQ_CTRL_C = 4'h5;
  localparam logic [3:0] ADDR_TIMER_LO = 4'h6;
  localparam logic [3:0] ADDR_TIMER_HI = 4'h7;
  localparam logic [3:0] ADDR_TIMER_CFG = 4'h8;
  localparam logic [3:0] ADDR_SAVED_W = 4'h9;
  localparam logic [3:0] ADDR_SAVED_STATUS = 4'hA;
  localparam logic [3:0] ADDR_SAVED_BANK = 4'hB;
  // Reset values and implemented-bit masks
  localparam logic [7:0] PRIO_TWO_MASK = 8'h95;
  localparam logic [7:0] PRIO_THREE_MASK = 8'h1F;
  localparam logic [7:0] RESET_CAUSE_INIT = 8'h1C;
  localparam logic [7:0] RESET_CAUSE_WMASK = 8'h93;
  localparam logic [7:0] IRQ_CTRL_B_INIT = 8'h75;
  localparam logic [7:0] IRQ_CTRL_C_INIT = 8'hC0;
  // Field positions
  localparam int PRIO_EN_BIT = 7;
  localparam int GLOBAL_IRQ_EN_BIT = 7;
  localparam int PERIPH_IRQ_EN_BIT = 6;
  localparam int T0_EN_BIT = 5;
  localparam int E0_EN_BIT = 4;
  localparam int PC_EN_BIT = 3;
  localparam int T0_FLAG_BIT = 2;
  localparam int E0_FLAG_BIT = 1;
  localparam int PC_FLAG_BIT = 0;
  localparam int EDGE0_BIT = 6;
  localparam int EDGE1_BIT = 5;
  localparam int EDGE2_BIT = 4;
  localparam int T0_PRIO_BIT = 2;
  localparam int PC_PRIO_BIT = 0;
  localparam int E2_PRIO_BIT = 7;
  localparam int E1_PRIO_BIT = 6;
  localparam int E2_EN_BIT = 4;
  localparam int E1_EN_BIT = 3;
  localparam int E2_FLAG_BIT = 1;
  localparam int E1_FLAG_BIT = 0;
  localparam int T0_WIDE_BIT = 0;
  localparam int T0_RUN_BIT = 1;
endpackage

//--- irq_prio_sources.sv
// Purpose: Priority bits, reset-cause register, pin, timer and port-change interrupt sources
// Assumes: Inputs synchronous to ref_clk; single clock; core consumes high/low requests
// Notes: Flag set wins over a software clear in the same cycle
// Operation
// [RULE1] Priority one means high, resets to one
// [RULE2] Second priority register layout, gaps read zero
// [RULE3] Bit three: capture three or direction
// [RULE4] Bit two: capture two or encoder
// [RULE5] PWM, capture one, timer five; top zero
// [RULE6] Priority enable at bit seven, resets zero
// [RULE7] Reset-cause flags; timeout and power-down read-only
// [RULE8] External pins edge triggered, selectable polarity
// [RULE9] Valid edge sets flag; software clears
// [RULE10] Enabled pin wakes; vector only with global
// [RULE11] Ext one, two priority from control C
// [RULE12] Ext zero always high priority
// [RULE13] Timer zero overflow at FFh or FFFFh
// [RULE14] Timer enable bit five, priority control B
// [RULE15] Port B upper nibble change sets flag
// [RULE16] Port-change enable bit three, priority bit zero
// [RULE17] Entry saves working, status, bank registers
// [RULE18] Software saves context without fast return
// [RULE19] Single level needs peripheral enable set
// [RULE20] Priority bits act only when enabled
// [RULE21] Enabled pending source drives its class request
`timescale 1ns/10ps
`default_nettype none
module irq_prio_sources
  import irq_prio_pkg::*;
#(
  parameter int PERIPH_COUNT = 9
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic [2:0] ext_pin,
  input wire logic [7:0] port_b_in,
  input wire logic [PERIPH_COUNT-1:0] periph_pending,
  input wire logic quad_encoder_active,
  input wire logic sleep_mode,
  input wire logic wdt_timeout_evt,
  input wire logic sleep_entry_evt,
  input wire logic entry_ack,
  input wire logic [7:0] core_working,
  input wire logic [7:0] core_status,
  input wire logic [7:0] core_bank,
  output logic irq_high,
  output logic irq_low,
  output logic wake_up
);
  // Elaboration check: the steering below is written for nine lines
  if (PERIPH_COUNT != 9) begin : g_count_check
    $error("PERIPH_COUNT must be 9");
  end

  logic [7:0] prio_two_reg;      // Second peripheral priority
  logic [7:0] prio_three_reg;    // Third peripheral priority
  logic [7:0] reset_cause_reg;   // Priority enable and cause flags
  logic [7:0] irq_ctrl_reg;      // Enables and flags
  logic [7:0] irq_ctrl_b_reg;    // Edge selects and priorities
  logic [7:0] irq_ctrl_c_reg;    // Ext one/two priority, enable, flag
  logic [15:0] timer_reg;        // Timer zero count
  logic [1:0] timer_cfg_reg;     // Wide mode and run
  logic [7:0] saved_w_reg;       // Shadow working register
  logic [7:0] saved_status_reg;  // Shadow status
  logic [7:0] saved_bank_reg;    // Shadow bank select
  logic [2:0] ext_prev_reg;      // Last pin levels
  logic [3:0] port_prev_reg;     // Last upper-nibble levels
  logic [2:0] ext_edge;          // Valid edge per pin
  logic port_change;
  logic timer_wrap;
  logic [15:0] timer_next;
  logic [PERIPH_COUNT-1:0] periph_prio;
  logic wr_ctrl;
  logic wr_ctrl_c;

  // Edge qualifying per pin polarity
  always_comb begin
    ext_edge[0] = irq_ctrl_b_reg[EDGE0_BIT] ? (ext_pin[0] & ~ext_prev_reg[0])
                                            : (~ext_pin[0] & ext_prev_reg[0]); // [RULE8]
    ext_edge[1] = irq_ctrl_b_reg[EDGE1_BIT] ? (ext_pin[1] & ~ext_prev_reg[1])
                                            : (~ext_pin[1] & ext_prev_reg[1]); // [RULE8]
    ext_edge[2] = irq_ctrl_b_reg[EDGE2_BIT] ? (ext_pin[2] & ~ext_prev_reg[2])
                                            : (~ext_pin[2] & ext_prev_reg[2]); // [RULE8]
  end

  // Any change on the upper nibble of port B
  assign port_change = |(port_b_in[7:4] ^ port_prev_reg); // [RULE15]

  // Timer wrap: 8-bit unless wide mode selected
  assign timer_next = timer_reg + 16'h0001;
  assign timer_wrap = timer_cfg_reg[T0_RUN_BIT] &
                      (timer_cfg_reg[T0_WIDE_BIT] ? (timer_reg == 16'hFFFF)
                                                  : (timer_reg[7:0] == 8'hFF)); // [RULE13]

  assign wr_ctrl = wr_stb && (addr == ADDR_IRQ_CTRL);
  assign wr_ctrl_c = wr_stb && (addr == ADDR_IRQ_CTRL_C);

  // Input history for edge and change detection
  // Tracks the live levels in reset too, so a pin held high across
  // release does not look like an edge afterwards
  always_ff @(posedge ref_clk) begin
    ext_prev_reg <= ext_pin;
    port_prev_reg <= port_b_in[7:4];
  end

  // Peripheral priority registers; unimplemented bits never store
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prio_two_reg <= PRIO_TWO_MASK;     // [RULE1]
      prio_three_reg <= PRIO_THREE_MASK; // [RULE1]
    end else if (wr_stb) begin
      if (addr == ADDR_PRIO_TWO) begin
        prio_two_reg <= wdata & PRIO_TWO_MASK; // [RULE2]
      end
      if (addr == ADDR_PRIO_THREE) begin
        prio_three_reg <= wdata & PRIO_THREE_MASK; // [RULE5]
      end
    end
  end

  // Reset-cause register; timeout and power-down cleared by hardware only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reset_cause_reg <= RESET_CAUSE_INIT; // [RULE6] [RULE7]
    end else begin
      if (wr_stb && (addr == ADDR_RESET_CAUSE)) begin
        reset_cause_reg <= (reset_cause_reg & ~RESET_CAUSE_WMASK) |
                           (wdata & RESET_CAUSE_WMASK); // [RULE7]
      end
      // Hardware events clear the active-low status bits
      if (wdt_timeout_evt) begin
        reset_cause_reg[3] <= 1'b0; // [RULE7]
      end
      if (sleep_entry_evt) begin
        reset_cause_reg[2] <= 1'b0; // [RULE7]
      end
    end
  end

  // Main control: enables by write, flags set-wins-over-clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_ctrl_reg <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        irq_ctrl_reg <= wdata;
      end
      if (timer_wrap) begin
        irq_ctrl_reg[T0_FLAG_BIT] <= 1'b1; // [RULE13]
      end
      if (ext_edge[0]) begin
        irq_ctrl_reg[E0_FLAG_BIT] <= 1'b1; // [RULE9]
      end
      if (port_change) begin
        irq_ctrl_reg[PC_FLAG_BIT] <= 1'b1; // [RULE15]
      end
    end
  end

  // Secondary control registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_ctrl_b_reg <= IRQ_CTRL_B_INIT;
      irq_ctrl_c_reg <= IRQ_CTRL_C_INIT;
    end else begin
      if (wr_stb && (addr == ADDR_IRQ_CTRL_B)) begin
        irq_ctrl_b_reg <= wdata;
      end
      if (wr_ctrl_c) begin
        irq_ctrl_c_reg <= wdata;
      end
      if (ext_edge[1]) begin
        irq_ctrl_c_reg[E1_FLAG_BIT] <= 1'b1; // [RULE9]
      end
      if (ext_edge[2]) begin
        irq_ctrl_c_reg[E2_FLAG_BIT] <= 1'b1; // [RULE9]
      end
    end
  end

  // Timer zero counter; software may load either byte
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timer_reg <= 16'h0000;
      timer_cfg_reg <= 2'h0;
    end else if (wr_stb && (addr == ADDR_TIMER_LO)) begin
      timer_reg[7:0] <= wdata;
    end else if (wr_stb && (addr == ADDR_TIMER_HI)) begin
      timer_reg[15:8] <= wdata;
    end else if (wr_stb && (addr == ADDR_TIMER_CFG)) begin
      timer_cfg_reg <= wdata[1:0];
    end else if (timer_cfg_reg[T0_RUN_BIT]) begin
      // In 8-bit mode the high byte holds still
      if (timer_cfg_reg[T0_WIDE_BIT]) begin
        timer_reg <= timer_next; // [RULE13]
      end else begin
        timer_reg[7:0] <= timer_next[7:0]; // [RULE13]
      end
    end
  end

  // Shadow copy of core context on interrupt entry
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      saved_w_reg <= 8'h00;
      saved_status_reg <= 8'h00;
      saved_bank_reg <= 8'h00;
    end else if (entry_ack) begin
      saved_w_reg <= core_working;    // [RULE17]
      saved_status_reg <= core_status; // [RULE17]
      saved_bank_reg <= core_bank;     // [RULE17]
    end
  end

  // Bit 3 and 2 of the third register follow the encoder when active
  always_comb begin
    periph_prio[0] = prio_two_reg[7];
    periph_prio[1] = prio_two_reg[4];
    periph_prio[2] = prio_two_reg[2];
    periph_prio[3] = prio_two_reg[0];
    periph_prio[4] = prio_three_reg[4];
    periph_prio[5] = prio_three_reg[3]; // [RULE3]
    periph_prio[6] = prio_three_reg[2]; // [RULE4]
    periph_prio[7] = prio_three_reg[1];
    periph_prio[8] = prio_three_reg[0];
  end

  // Request steering to the core
  logic prio_en;
  logic global_irq_enable;
  logic [3:0] src_pend;
  logic [2:0] src_prio;
  logic periph_hi;
  logic periph_lo;
  assign prio_en = reset_cause_reg[PRIO_EN_BIT];
  assign global_irq_enable = irq_ctrl_reg[GLOBAL_IRQ_EN_BIT];
  assign src_pend[0] = irq_ctrl_reg[E0_FLAG_BIT] & irq_ctrl_reg[E0_EN_BIT];
  assign src_pend[1] = irq_ctrl_c_reg[E1_FLAG_BIT] & irq_ctrl_c_reg[E1_EN_BIT];
  assign src_pend[2] = irq_ctrl_c_reg[E2_FLAG_BIT] & irq_ctrl_c_reg[E2_EN_BIT];
  assign src_pend[3] = (irq_ctrl_reg[T0_FLAG_BIT] & irq_ctrl_reg[T0_EN_BIT]) |
                       (irq_ctrl_reg[PC_FLAG_BIT] & irq_ctrl_reg[PC_EN_BIT]);
  assign src_prio[0] = 1'b1; // [RULE12]
  assign src_prio[1] = irq_ctrl_c_reg[E1_PRIO_BIT]; // [RULE11]
  assign src_prio[2] = irq_ctrl_c_reg[E2_PRIO_BIT]; // [RULE11]
  assign periph_hi = |(periph_pending & periph_prio);
  assign periph_lo = |(periph_pending & ~periph_prio);

  always_comb begin
    if (!global_irq_enable) begin
      irq_high = 1'b0;
      irq_low = 1'b0;
    end else if (prio_en) begin
      // Two levels: each source goes to its class; low needs the peripheral enable
      irq_high = |(src_pend[2:0] & src_prio[2:0]) | periph_hi |
                 (irq_ctrl_reg[T0_FLAG_BIT] & irq_ctrl_reg[T0_EN_BIT] &
                  irq_ctrl_b_reg[T0_PRIO_BIT]) |
                 (irq_ctrl_reg[PC_FLAG_BIT] & irq_ctrl_reg[PC_EN_BIT] &
                  irq_ctrl_b_reg[PC_PRIO_BIT]); // [RULE14] [RULE16] [RULE21]
      irq_low = irq_ctrl_reg[PERIPH_IRQ_EN_BIT] &
                (|(src_pend[2:0] & ~src_prio[2:0]) | periph_lo |
                 (irq_ctrl_reg[T0_FLAG_BIT] & irq_ctrl_reg[T0_EN_BIT] &
                  ~irq_ctrl_b_reg[T0_PRIO_BIT]) |
                 (irq_ctrl_reg[PC_FLAG_BIT] & irq_ctrl_reg[PC_EN_BIT] &
                  ~irq_ctrl_b_reg[PC_PRIO_BIT])); // [RULE21]
    end else begin
      // Single level: priorities ignored, peripherals need their enable
      irq_high = |src_pend | (irq_ctrl_reg[PERIPH_IRQ_EN_BIT] & (|periph_pending)); // [RULE20] [RULE19]
      irq_low = 1'b0;
    end
  end

  // Wake needs only the enables, not the global enable
  assign wake_up = sleep_mode & (|src_pend[2:0]); // [RULE10]

  // Read data, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        ADDR_PRIO_TWO: rdata <= prio_two_reg & PRIO_TWO_MASK;
        ADDR_PRIO_THREE: rdata <= prio_three_reg & PRIO_THREE_MASK;
        ADDR_RESET_CAUSE: rdata <= reset_cause_reg & 8'h9F;
        ADDR_IRQ_CTRL: rdata <= irq_ctrl_reg;
        ADDR_IRQ_CTRL_B: rdata <= irq_ctrl_b_reg;
        ADDR_IRQ_CTRL_C: rdata <= irq_ctrl_c_reg;
        ADDR_TIMER_LO: rdata <= timer_reg[7:0];
        ADDR_TIMER_HI: rdata <= timer_reg[15:8];
        ADDR_TIMER_CFG: rdata <= {6'h00, timer_cfg_reg};
        ADDR_SAVED_W: rdata <= saved_w_reg;
        ADDR_SAVED_STATUS: rdata <= saved_status_reg;
        ADDR_SAVED_BANK: rdata <= saved_bank_reg;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Checks
  property p_prio_reset;
    @(posedge ref_clk) $fell(srst) |-> (prio_two_reg == PRIO_TWO_MASK);
  endproperty
  a_prio_reset: assert property (p_prio_reset) else $error("priority reset wrong"); // [RULE1]

  property p_prio_two_gaps;
    @(posedge ref_clk) disable iff (srst) (prio_two_reg & 8'h6A) == 8'h00;
  endproperty
  a_prio_two_gaps: assert property (p_prio_two_gaps) else $error("gap bits set"); // [RULE2]

  property p_prio_three_gaps;
    @(posedge ref_clk) disable iff (srst) prio_three_reg[7:5] == 3'h0;
  endproperty
  a_prio_three_gaps: assert property (p_prio_three_gaps) else $error("top bits set"); // [RULE5]

  property p_ext0_flag;
    @(posedge ref_clk) disable iff (srst) ext_edge[0] |=> irq_ctrl_reg[E0_FLAG_BIT];
  endproperty
  a_ext0_flag: assert property (p_ext0_flag) else $error("ext zero flag lost"); // [RULE9]

  property p_rise_edge;
    @(posedge ref_clk) disable iff (srst)
      (irq_ctrl_b_reg[EDGE1_BIT] && !ext_prev_reg[1] && ext_pin[1]) |=> irq_ctrl_c_reg[E1_FLAG_BIT];
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rising edge missed"); // [RULE8]

  property p_timer_wrap;
    @(posedge ref_clk) disable iff (srst)
      (timer_cfg_reg == 2'h2 && timer_reg[7:0] == 8'hFF && !wr_stb) |=> irq_ctrl_reg[T0_FLAG_BIT];
  endproperty
  a_timer_wrap: assert property (p_timer_wrap) else $error("overflow flag missed"); // [RULE13]

  property p_port_change;
    @(posedge ref_clk) disable iff (srst)
      ($past(port_b_in[7:4]) != port_b_in[7:4]) |=> irq_ctrl_reg[PC_FLAG_BIT];
  endproperty
  a_port_change: assert property (p_port_change) else $error("change flag missed"); // [RULE15]

  property p_ext0_high;
    @(posedge ref_clk) disable iff (srst) (global_irq_enable && src_pend[0]) |-> irq_high;
  endproperty
  a_ext0_high: assert property (p_ext0_high) else $error("ext zero not high"); // [RULE12]

  property p_single_level;
    @(posedge ref_clk) disable iff (srst) !prio_en |-> !irq_low;
  endproperty
  a_single_level: assert property (p_single_level) else $error("low request without levels"); // [RULE20]

  property p_shadow;
    @(posedge ref_clk) disable iff (srst) entry_ack |=> (saved_w_reg == $past(core_working));
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow not saved"); // [RULE17]

  // Encoder active: bit three still steers the shared line
  property p_dir_class;
    @(posedge ref_clk) disable iff (srst)
      (global_irq_enable && prio_en && quad_encoder_active && periph_pending[5] &&
       prio_three_reg[3]) |-> irq_high;
  endproperty
  a_dir_class: assert property (p_dir_class) else $error("dir class wrong"); // [RULE3]

  // Capture mode: a cleared bit two sends capture two to the low class
  property p_cap_two_class;
    @(posedge ref_clk) disable iff (srst)
      (global_irq_enable && prio_en && !quad_encoder_active && periph_pending[6] &&
       irq_ctrl_reg[PERIPH_IRQ_EN_BIT] && !prio_three_reg[2]) |-> irq_low;
  endproperty
  a_cap_two_class: assert property (p_cap_two_class) else $error("cap two class wrong"); // [RULE4]

  // Timer overflow with a cleared priority bit goes low
  property p_timer_class;
    @(posedge ref_clk) disable iff (srst)
      (global_irq_enable && prio_en && irq_ctrl_reg[T0_FLAG_BIT] && irq_ctrl_reg[T0_EN_BIT] &&
       irq_ctrl_reg[PERIPH_IRQ_EN_BIT] && !irq_ctrl_b_reg[T0_PRIO_BIT]) |-> irq_low;
  endproperty
  a_timer_class: assert property (p_timer_class) else $error("timer class wrong"); // [RULE14]

  // Port change with its priority bit set goes high
  property p_change_class;
    @(posedge ref_clk) disable iff (srst)
      (global_irq_enable && prio_en && irq_ctrl_reg[PC_FLAG_BIT] && irq_ctrl_reg[PC_EN_BIT] &&
       irq_ctrl_b_reg[PC_PRIO_BIT]) |-> irq_high;
  endproperty
  a_change_class: assert property (p_change_class) else $error("change class wrong"); // [RULE16]
endmodule
`default_nettype wire

//--- test_interrupt_priority_sources.sv
// Purpose: Self-checking bench for the priority and source block
// Assumes: Register port with read data one cycle after the strobe
// Notes: Irq outputs are compared as a pair, high in bit 1, low in bit 0
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_priority_sources;
  import irq_prio_pkg::*;
  logic ref_clk = 1'b0; // 20 MHz clock
  logic srst = 1'b1; // Held for two edges
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic [2:0] ext_pin = 3'h0; // Pin levels
  logic [7:0] port_b_in = 8'h00;
  logic [8:0] periph_pending = 9'h000;
  logic quad_encoder_active = 1'b0;
  logic sleep_mode = 1'b0;
  logic wdt_timeout_evt = 1'b0;
  logic sleep_entry_evt = 1'b0;
  logic entry_ack, irq_high, irq_low, wake_up;
  logic [7:0] core_working, core_status, core_bank;
  logic take_en = 1'b0; // Arms the core model
  logic [3:0] ack_delay = 4'h3; // Slow core answer
  int fails = 0;
  int n_compared = 0;
  // Priority bit of each pending line, in its register
  logic [7:0] pos_tab [9] = '{8'h80, 8'h10, 8'h04, 8'h01, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
  // Free-running clock
  always #25 ref_clk = ~ref_clk;
  irq_prio_sources #(.PERIPH_COUNT(9)) u_dut (.ref_clk(ref_clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ext_pin(ext_pin),
    .port_b_in(port_b_in), .periph_pending(periph_pending),
    .quad_encoder_active(quad_encoder_active),
    .sleep_mode(sleep_mode), .wdt_timeout_evt(wdt_timeout_evt),
    .sleep_entry_evt(sleep_entry_evt), .entry_ack(entry_ack), .core_working(core_working),
    .core_status(core_status), .core_bank(core_bank), .irq_high(irq_high), .irq_low(irq_low),
    .wake_up(wake_up));
  core_model u_core (.ref_clk(ref_clk), .irq_high(irq_high), .irq_low(irq_low),
    .take_en(take_en), .ack_delay(ack_delay), .entry_ack(entry_ack),
    .core_working(core_working), .core_status(core_status), .core_bank(core_bank));
  // Single compare; four-state so unknowns never match
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  // Read strobe, then sample data in the following cycle only
  task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  // Let n edges pass, then step off the edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Compare the request pair
  task automatic irq(input logic h, input logic l);
    step(2);
    chk("irq_pair", {6'h00, h, l}, {6'h00, irq_high, irq_low});
  endtask
  task automatic pins(input logic [2:0] v);
    @(posedge ref_clk);
    ext_pin <= v;
    step(3);
  endtask
  // Reset values and an unmapped read
  task automatic t_reset;
    rd("prio_two", ADDR_PRIO_TWO, 8'h95);
    rd("prio_three", ADDR_PRIO_THREE, 8'h1F);
    rd("reset_cause", ADDR_RESET_CAUSE, 8'h1C);
    rd("ctrl_b", ADDR_IRQ_CTRL_B, 8'h75);
    rd("ctrl_c", ADDR_IRQ_CTRL_C, 8'hC0);
    rd("unmapped", 4'hF, 8'h00);
  endtask
  // Reserved and read-only bits, event clears
  task automatic t_access;
    wr(ADDR_PRIO_TWO, 8'hFF);
    rd("prio_two", ADDR_PRIO_TWO, 8'h95);
    wr(ADDR_PRIO_TWO, 8'h00);
    rd("prio_two", ADDR_PRIO_TWO, 8'h00);
    wr(ADDR_PRIO_THREE, 8'hE0);
    rd("prio_three", ADDR_PRIO_THREE, 8'h00);
    wr(ADDR_RESET_CAUSE, 8'h00);
    rd("reset_cause", ADDR_RESET_CAUSE, 8'h0C);
    @(posedge ref_clk);
    wdt_timeout_evt <= 1'b1;
    @(posedge ref_clk);
    wdt_timeout_evt <= 1'b0;
    rd("reset_cause", ADDR_RESET_CAUSE, 8'h04);
    @(posedge ref_clk);
    sleep_entry_evt <= 1'b1;
    @(posedge ref_clk);
    sleep_entry_evt <= 1'b0;
    wr(ADDR_RESET_CAUSE, 8'hFF);
    rd("reset_cause", ADDR_RESET_CAUSE, 8'h93);
    wr(ADDR_PRIO_TWO, PRIO_TWO_MASK);
    wr(ADDR_PRIO_THREE, PRIO_THREE_MASK);
  endtask
  // Every peripheral line in both classes, then single-level mode
  task automatic t_periph;
    logic [3:0] a;
    logic [7:0] m;
    wr(ADDR_IRQ_CTRL, 8'hC0);
    for (int i = 0; i < 9; i++) begin
      a = (i < 4) ? ADDR_PRIO_TWO : ADDR_PRIO_THREE;
      m = (i < 4) ? PRIO_TWO_MASK : PRIO_THREE_MASK;
      @(posedge ref_clk);
      periph_pending <= 9'h001 << i;
      quad_encoder_active <= i[0];
      irq(1'b1, 1'b0);
      wr(a, m & ~pos_tab[i]);
      irq(1'b0, 1'b1);
      if (i < 8) wr(a, m);
    end
    wr(ADDR_RESET_CAUSE, 8'h00);
    irq(1'b1, 1'b0);
    wr(ADDR_IRQ_CTRL, 8'h80);
    irq(1'b0, 1'b0);
    @(posedge ref_clk);
    periph_pending <= 9'h000;
    wr(ADDR_RESET_CAUSE, 8'h80);
    wr(ADDR_IRQ_CTRL, 8'hC0);
  endtask
  // Pin edges, polarity, priorities and wake-up
  task automatic t_ext;
    wr(ADDR_IRQ_CTRL_C, 8'hC8);
    pins(3'b010);
    rd("ctrl_c", ADDR_IRQ_CTRL_C, 8'hC9);
    irq(1'b1, 1'b0);
    wr(ADDR_IRQ_CTRL_C, 8'h88);
    pins(3'b000);
    rd("ctrl_c", ADDR_IRQ_CTRL_C, 8'h88);
    wr(ADDR_IRQ_CTRL_B, 8'h55);
    pins(3'b010);
    pins(3'b000);
    rd("ctrl_c", ADDR_IRQ_CTRL_C, 8'h89);
    irq(1'b0, 1'b1);
    @(posedge ref_clk);
    sleep_mode <= 1'b1;
    step(2);
    chk("wake_up", 8'h01, {7'h00, wake_up});
    wr(ADDR_IRQ_CTRL_C, 8'h91);
    irq(1'b0, 1'b0);
    chk("wake_up", 8'h00, {7'h00, wake_up});
    pins(3'b100);
    chk("wake_up", 8'h01, {7'h00, wake_up});
    rd("ctrl_c", ADDR_IRQ_CTRL_C, 8'h93);
    irq(1'b1, 1'b0);
    @(posedge ref_clk);
    sleep_mode <= 1'b0;
    wr(ADDR_IRQ_CTRL_C, 8'hC0);
    wr(ADDR_IRQ_CTRL_B, 8'h75);
    wr(ADDR_IRQ_CTRL, 8'hD0);
    pins(3'b101);
    rd("ctrl", ADDR_IRQ_CTRL, 8'hD2);
    irq(1'b1, 1'b0);
    wr(ADDR_IRQ_CTRL, 8'hC0);
    pins(3'b000);
    wr(ADDR_IRQ_CTRL_B, 8'h75);
  endtask
  // Load, run a few cycles, stop
  task automatic run_timer(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] cfg);
    wr(ADDR_TIMER_HI, hi);
    wr(ADDR_TIMER_LO, lo);
    wr(ADDR_TIMER_CFG, cfg);
    step(3);
    wr(ADDR_TIMER_CFG, 8'h00);
  endtask
  // Timer wraps in both widths
  task automatic t_timer;
    run_timer(8'h00, 8'hFF, 8'h02);
    rd("ctrl", ADDR_IRQ_CTRL, 8'hC4);
    wr(ADDR_IRQ_CTRL_B, 8'h71);
    wr(ADDR_IRQ_CTRL, 8'hE4);
    irq(1'b0, 1'b1);
    wr(ADDR_IRQ_CTRL, 8'hC0);
    run_timer(8'h00, 8'hFF, 8'h03);
    rd("ctrl", ADDR_IRQ_CTRL, 8'hC0);
    run_timer(8'hFF, 8'hFF, 8'h03);
    rd("ctrl", ADDR_IRQ_CTRL, 8'hC4);
    wr(ADDR_IRQ_CTRL, 8'hC0);
    wr(ADDR_IRQ_CTRL_B, 8'h75);
  endtask
  // Port change, then core entry and context save
  task automatic t_change_entry;
    wr(ADDR_IRQ_CTRL, 8'hC8);
    @(posedge ref_clk);
    port_b_in <= 8'h0F;
    rd("ctrl", ADDR_IRQ_CTRL, 8'hC8);
    @(posedge ref_clk);
    port_b_in <= 8'h8F;
    rd("ctrl", ADDR_IRQ_CTRL, 8'hC9);
    irq(1'b1, 1'b0);
    wr(ADDR_IRQ_CTRL_B, 8'h74);
    irq(1'b0, 1'b1);
    @(posedge ref_clk);
    take_en <= 1'b1;
    for (int k = 0; k < 50 && entry_ack !== 1'b1; k++) step(1);
    chk("entry_ack", 8'h01, {7'h00, entry_ack});
    @(posedge ref_clk);
    take_en <= 1'b0;
    rd("saved_w", ADDR_SAVED_W, 8'h5A);
    rd("saved_status", ADDR_SAVED_STATUS, 8'hC3);
    rd("saved_bank", ADDR_SAVED_BANK, 8'h0E);
  endtask
  // Verdict and end of run
  task automatic give_verdict;
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset;
    t_access;
    t_periph;
    t_ext;
    t_timer;
    t_change_entry;
    give_verdict;
  end
  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    give_verdict;
  end
endmodule
`default_nettype wire
